// File: rtl/bcs_top.v
// battery charge sequencer with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.vh"
module bcs_top #(
    parameter TRICKLE_CYC = `BCS_TRICKLE_MS * `BCS_CLK_KHZ,
    parameter SAMPLE_W = 12,
    parameter LSB_UV = 1000
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // comparator results
    input wire batt_below_lbat,
    input wire batt_at_mcv,
    input wire batt_below_rch,
    input wire temp_hot,
    input wire temp_cold,
    input wire temp_cutoff,
    input wire cur_below_min,
    input wire cur_below_max,
    input wire battery_present,
    // timebase tick from the timer program input
    input wire timer_program_in,
    // sampled battery sense voltage
    input wire [SAMPLE_W-1:0] battery_sense_in,
    input wire battery_sense_valid,
    // charge switch and status indicator
    output reg charge_switch_out,
    output reg status_indicator_out,
    output reg status_indicator_oe
);

// ****************************************
// constants and states
// ****************************************
// peak drop in sample steps, rounded up
localparam [31:0] PEAK_DROP =
    (`BCS_PEAK_DROP_UV + LSB_UV - 1) / LSB_UV;
localparam [SAMPLE_W-1:0] PEAK_LSB = PEAK_DROP[SAMPLE_W-1:0];
localparam [31:0] TRK_M1 = TRICKLE_CYC - 1; // last phase count
localparam [31:0] TRK_H = TRICKLE_CYC / 2; // half period
localparam [27:0] TRK_LAST = TRK_M1[27:0];
localparam [27:0] TRK_HALF = TRK_H[27:0];
localparam [3:0] S_QUAL = 4'h0; // qualification
localparam [3:0] S_PEND = 4'h1; // charge pending
localparam [3:0] S_FAST = 4'h2; // early cc, chemistry open
localparam [3:0] S_NI = 4'h3; // nickel fast charge
localparam [3:0] S_TOP = 4'h4; // nickel top-off
localparam [3:0] S_NTRK = 4'h5; // nickel maintenance
localparam [3:0] S_LICV = 4'h6; // lithium constant voltage
localparam [3:0] S_DONE = 4'h7; // lithium finished
localparam [3:0] S_HALT = 4'h8; // sleep or no battery

// byte-lane merge of a write into a register
function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
        wmerge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                wmerge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    end
endfunction

// ****************************************
// registered comparator inputs
// ****************************************
reg lbat_q; // below low battery threshold
reg mcv_q; // at max cell voltage ref
reg rch_q; // below recharge threshold
reg hot_q; // beyond high temp fault
reg cold_q; // beyond low temp fault
reg cut_q; // beyond temperature cutoff
reg imin_q; // current below minimum
reg imax_q; // current below regulation point
reg pres_q; // battery present
reg tick_q; // timebase tick
reg [SAMPLE_W-1:0] smp_q; // battery sample
reg smpv_q; // sample valid

// sample every comparator once before use
always @(posedge aclk) begin
    if (!aresetn) begin
        lbat_q <= 1'b1;
        mcv_q <= 1'b0;
        rch_q <= 1'b0;
        hot_q <= 1'b0;
        cold_q <= 1'b0;
        cut_q <= 1'b0;
        imin_q <= 1'b0;
        imax_q <= 1'b0;
        pres_q <= 1'b0;
        tick_q <= 1'b0;
        smp_q <= {SAMPLE_W{1'b0}};
        smpv_q <= 1'b0;
    end else begin
        lbat_q <= batt_below_lbat;
        mcv_q <= batt_at_mcv;
        rch_q <= batt_below_rch;
        hot_q <= temp_hot;
        cold_q <= temp_cold;
        cut_q <= temp_cutoff;
        imin_q <= cur_below_min;
        imax_q <= cur_below_max;
        pres_q <= battery_present;
        tick_q <= timer_program_in;
        smp_q <= battery_sense_in;
        smpv_q <= battery_sense_valid;
    end
end

// ****************************************
// software registers
// ****************************************
reg [1:0] ctrl_q; // top-off enable, sleep
reg [23:0] tout_q; // timeout in timebase ticks
reg [27:0] twid_q; // trickle pulse width, cycles
reg [3:0] st_q; // charge state
reg [3:0] st_d;
reg li_q; // lithium detected
reg known_q; // chemistry decided
reg [23:0] tmr_q; // charge timer in ticks
reg [27:0] trk_q; // one second trickle phase
reg [SAMPLE_W-1:0] max_q; // running max sample
reg aw_q; // write address held
reg w_q; // write data held
reg [7:0] awa_q; // held write address
reg [31:0] wd_q; // held write data
reg [3:0] ws_q; // held write strobes

wire aw_hs = s_axi_awvalid & s_axi_awready;
wire w_hs = s_axi_wvalid & s_axi_wready;
wire ar_hs = s_axi_arvalid & s_axi_arready;
wire do_wr = aw_q & w_q & ~s_axi_bvalid;
wire wr_ctrl = do_wr & (awa_q == `BCS_ADDR_CTRL);
wire wr_tout = do_wr & (awa_q == `BCS_ADDR_TOUT);
wire wr_twid = do_wr & (awa_q == `BCS_ADDR_TWID);
wire wr_ok = wr_ctrl | wr_tout | wr_twid;
wire [31:0] ctrl_w = wmerge({30'h0, ctrl_q}, wd_q, ws_q);
wire [31:0] tout_w = wmerge({8'h0, tout_q}, wd_q, ws_q);
wire [31:0] twid_w = wmerge({4'h0, twid_q}, wd_q, ws_q);

// write channel: address and data in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        awa_q <= 8'h00;
        wd_q <= 32'h0;
        ws_q <= 4'h0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `BCS_RESP_OK;
        ctrl_q <= `BCS_CTRL_RST;
        tout_q <= `BCS_TOUT_RST;
        twid_q <= `BCS_TWID_RST;
    end else begin
        if (aw_hs) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (w_hs) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        // both held: commit and answer
        if (do_wr) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `BCS_RESP_OK : `BCS_RESP_ERR;
        end
        if (wr_ctrl) begin
            ctrl_q <= ctrl_w[1:0];
        end
        if (wr_tout) begin
            tout_q <= tout_w[23:0];
        end
        if (wr_twid) begin
            twid_q <= twid_w[27:0];
        end
        // response taken: reopen both channels
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// read channel: data one cycle after the address
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `BCS_RESP_OK;
    end else if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BCS_RESP_OK;
        case (s_axi_araddr)
            `BCS_ADDR_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
            `BCS_ADDR_TOUT: s_axi_rdata <= {8'h0, tout_q};
            `BCS_ADDR_TWID: s_axi_rdata <= {4'h0, twid_q};
            `BCS_ADDR_STAT: begin
                s_axi_rdata <= {24'h0, status_indicator_oe,
                    charge_switch_out, known_q, li_q, st_q};
            end
            `BCS_ADDR_TMR: s_axi_rdata <= {8'h0, tmr_q};
            default: begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `BCS_RESP_ERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

// ****************************************
// timing
// ****************************************
wire temp_ok = ~hot_q & ~cold_q;
wire timeout = tmr_q >= tout_q;
wire hold_done = tmr_q >= (tout_q >> `BCS_HOLDOFF_SHIFT);
wire pulse = trk_q < twid_q;
wire flash = trk_q < TRK_HALF;
wire top_slot = trk_q[`BCS_TOPOFF_BITS-1:0] ==
    {`BCS_TOPOFF_BITS{1'b0}};
wire peak_det = smpv_q && (max_q > smp_q) &&
    ((max_q - smp_q) >= PEAK_LSB);
wire enter = st_d != st_q;

// free one second phase for trickle and flashing
always @(posedge aclk) begin
    if (!aresetn) begin
        trk_q <= 28'h0;
    end else if (trk_q >= TRK_LAST) begin
        trk_q <= 28'h0;
    end else begin
        trk_q <= trk_q + 28'h1;
    end
end

// charge timer counts timebase ticks
always @(posedge aclk) begin
    if (!aresetn) begin
        tmr_q <= 24'h0;
    end else if (enter && (st_d == S_FAST || st_d == S_TOP ||
            st_d == S_LICV)) begin
        tmr_q <= 24'h0;
    end else if (tick_q && !timeout) begin
        tmr_q <= tmr_q + 24'h1;
    end
end

// running maximum of the battery samples
always @(posedge aclk) begin
    if (!aresetn) begin
        max_q <= {SAMPLE_W{1'b0}};
    end else if (st_q != S_FAST && st_q != S_NI) begin
        max_q <= {SAMPLE_W{1'b0}};
    end else if (smpv_q && smp_q > max_q) begin
        max_q <= smp_q;
    end
end

// ****************************************
// charge state machine
// ****************************************
// next state
always @* begin
    st_d = st_q;
    if (ctrl_q[`BCS_CTRL_SLEEP] || !pres_q) begin
        st_d = S_HALT;
    end else begin
        case (st_q)
            S_HALT: st_d = S_QUAL;
            S_QUAL: begin
                if (lbat_q) begin
                    st_d = S_PEND;
                end else if (temp_ok) begin
                    st_d = S_FAST;
                end
            end
            S_PEND: begin
                if (!lbat_q && temp_ok) begin
                    st_d = S_FAST;
                end else if (!lbat_q) begin
                    st_d = S_QUAL;
                end
            end
            S_FAST: begin
                if (cut_q) begin
                    st_d = S_NTRK;
                end else if (mcv_q) begin
                    st_d = S_LICV;
                end else if (hold_done) begin
                    st_d = S_NI;
                end
            end
            S_NI: begin
                if (cut_q || timeout || (peak_det && hold_done)) begin
                    st_d = ctrl_q[`BCS_CTRL_TOPOFF] ?
                        S_TOP : S_NTRK;
                end
            end
            S_TOP: begin
                if (timeout || cut_q) begin
                    st_d = S_NTRK;
                end
            end
            S_NTRK: st_d = S_NTRK;
            S_LICV: begin
                if (imin_q || timeout || cut_q) begin
                    st_d = S_DONE;
                end
            end
            S_DONE: begin
                if (rch_q) begin
                    st_d = S_QUAL;
                end
            end
            default: st_d = S_QUAL;
        endcase
    end
end

// state register and chemistry flags
always @(posedge aclk) begin
    if (!aresetn) begin
        st_q <= S_QUAL;
        li_q <= 1'b0;
        known_q <= 1'b0;
    end else begin
        st_q <= st_d;
        if (st_d == S_QUAL) begin
            li_q <= 1'b0;
            known_q <= 1'b0;
        end else if (st_q == S_FAST && st_d == S_LICV) begin
            li_q <= 1'b1;
            known_q <= 1'b1;
        end else if (st_q == S_FAST && st_d == S_NI) begin
            known_q <= 1'b1;
        end
    end
end

// ****************************************
// charge switch and indicator
// ****************************************
reg sw_d; // next charge switch level
reg ind_d; // next indicator sink enable

// switch and indicator per state
always @* begin
    sw_d = 1'b0;
    ind_d = 1'b0;
    case (st_q)
        S_PEND: begin
            sw_d = pulse & ~hot_q;
            ind_d = flash;
        end
        S_FAST: begin
            sw_d = imax_q;
            ind_d = 1'b1;
        end
        S_NI: begin
            sw_d = imax_q;
            ind_d = 1'b1;
        end
        S_TOP: begin
            sw_d = imax_q & top_slot & ~mcv_q & ~hot_q;
            ind_d = 1'b1;
        end
        S_NTRK: begin
            sw_d = pulse & ~mcv_q & ~hot_q;
        end
        S_LICV: begin
            sw_d = imax_q & ~mcv_q;
            ind_d = 1'b1;
        end
        S_DONE: sw_d = 1'b0;
        default: begin
            sw_d = 1'b0;
            ind_d = 1'b0;
        end
    endcase
end

// outputs from flip-flops
always @(posedge aclk) begin
    if (!aresetn) begin
        charge_switch_out <= 1'b0;
        status_indicator_out <= 1'b0;
        status_indicator_oe <= 1'b0;
    end else begin
        charge_switch_out <= sw_d;
        status_indicator_out <= 1'b0;
        status_indicator_oe <= ind_d;
    end
end

endmodule // bcs_top
`default_nettype wire

// File: rtl/bcs_defs.vh
// constants of the battery charge sequencer
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH
// register byte offsets
`define BCS_ADDR_CTRL 8'h00
`define BCS_ADDR_TOUT 8'h04
`define BCS_ADDR_TWID 8'h08
`define BCS_ADDR_STAT 8'h0C
`define BCS_ADDR_TMR 8'h10
// control fields
`define BCS_CTRL_TOPOFF 0
`define BCS_CTRL_SLEEP 1
// reset values
`define BCS_CTRL_RST 2'h0
`define BCS_TOUT_RST 24'h000800
`define BCS_TWID_RST 28'h0098968
// status fields
`define BCS_STAT_LI 4
`define BCS_STAT_KNOWN 5
`define BCS_STAT_SW 6
`define BCS_STAT_IND 7
// timing
`define BCS_HOLDOFF_SHIFT 5
`define BCS_TOPOFF_BITS 4
`define BCS_TRICKLE_MS 1000
`define BCS_CLK_KHZ 200000
`define BCS_PEAK_DROP_UV 3800
// axi responses
`define BCS_RESP_OK 2'h0
`define BCS_RESP_ERR 2'h2
`endif

// File: verif/bcs_plant.sv
// far-side model: rc timebase, current sense and indicator wire
`timescale 1ns/1ps
`default_nettype none
module bcs_plant #(
    parameter int TICK = 4
) (
    // clock
    input wire logic aclk,
    // from the sequencer
    input wire logic charge_switch_out,
    input wire logic status_indicator_oe,
    // to the sequencer, and the indicator wire to the testbench
    output logic timer_program_in,
    output logic cur_below_max,
    output logic ind_line
);
    int cnt = 0; // tick divider
    // one high cycle per tick of the rc timebase
    always @(posedge aclk) begin
        cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
        timer_program_in <= (cnt == TICK - 1);
    end
    // current reaches regulation while the switch passes it
    always @(posedge aclk) begin
        cur_below_max <= !charge_switch_out;
    end
    // pull-up wire: low only while the indicator sinks
    assign ind_line = status_indicator_oe ? 1'b0 : 1'b1;
endmodule // bcs_plant
`default_nettype wire

// File: verif/bcs_top_sva.sv
// port checker for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module bcs_top_sva (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // charge side
    input wire temp_hot,
    input wire temp_cutoff,
    input wire battery_present,
    input wire charge_switch_out,
    input wire status_indicator_out,
    input wire status_indicator_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_due;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_due: assert property (p_wr_due) else $error("write answer late");
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer lost");
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("ready while busy");
    property p_rd_err;
        s_rd_take ##0 (s_axi_araddr > 8'h10) |=> s_axi_rvalid && s_axi_rresp == 2'h2;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer lost");
    property p_od_data;
        status_indicator_out == 1'b0;
    endproperty
    a_od_data: assert property (p_od_data) else $error("indicator data high");
    property p_start_off;
        $rose(aresetn) |-> !charge_switch_out && !status_indicator_oe;
    endproperty
    a_start_off: assert property (p_start_off) else $error("switch on at start");
    property p_hot_stop;
        (temp_hot && temp_cutoff) [*6] |-> !charge_switch_out;
    endproperty
    a_hot_stop: assert property (p_hot_stop) else $error("switch on while hot");
    property p_absent_off;
        (!battery_present) [*6] |-> !charge_switch_out;
    endproperty
    a_absent_off: assert property (p_absent_off) else $error("switch on, no pack");
endmodule // bcs_top_sva
bind bcs_top bcs_top_sva chk_u (.*);
`default_nettype wire

// File: verif/bcs_top_tb.sv
// self-checking testbench of the charge sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.vh"
module bcs_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic batt_below_lbat, batt_at_mcv, batt_below_rch, temp_hot, temp_cold;
    logic temp_cutoff, cur_below_min, cur_below_max, battery_present;
    logic timer_program_in, battery_sense_valid, charge_switch_out;
    logic status_indicator_out, status_indicator_oe, ind_line;
    logic [11:0] battery_sense_in;
    int fail_count = 0, checks = 0, cyc = 0;
    // design with a short trickle period
    bcs_top #(.TRICKLE_CYC(64)) dut_u (.*);
    // far side of the charge link
    bcs_plant #(.TICK(4)) plant_u (.aclk(aclk),
        .charge_switch_out(charge_switch_out),
        .status_indicator_oe(status_indicator_oe),
        .timer_program_in(timer_program_in),
        .cur_below_max(cur_below_max), .ind_line(ind_line));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 60000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        @(posedge aclk);
    endtask
    // poll the state field until it shows s, bounded
    task automatic wait_st(input logic [3:0] s);
        for (int i = 0; i < 200; i++) begin
            rd(`BCS_ADDR_STAT, `BCS_RESP_OK);
            if (v[3:0] === s) break;
        end
        chk(v[3:0], s);
    endtask
    // count switch and indicator rises over a window
    task automatic rises(input int n, input int es, input int el);
        int ns, nl;
        logic ps, pl;
        ns = 0;
        nl = 0;
        ps = charge_switch_out;
        pl = !ind_line;
        repeat (n) begin
            @(posedge aclk);
            if (charge_switch_out && !ps) ns++;
            if (!ind_line && !pl) nl++;
            ps = charge_switch_out;
            pl = !ind_line;
        end
        chk(ns, es);
        if (el >= 0) chk(nl, el);
    endtask
    task automatic smp(input logic [11:0] s);
        battery_sense_in <= s;
        battery_sense_valid <= 1'b1;
        @(posedge aclk);
        battery_sense_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic t_regs;
        rd(`BCS_ADDR_CTRL, `BCS_RESP_OK);
        chk(v, `BCS_CTRL_RST);
        rd(`BCS_ADDR_TOUT, `BCS_RESP_OK);
        chk(v, `BCS_TOUT_RST);
        rd(`BCS_ADDR_TWID, `BCS_RESP_OK);
        chk(v, `BCS_TWID_RST);
        rd(8'h40, `BCS_RESP_ERR);
        chk(v, 32'h0);
        wr(`BCS_ADDR_STAT, 32'hF, `BCS_RESP_ERR);
        // one byte lane only: upper bytes keep their reset value
        s_axi_wstrb <= 4'h1;
        wr(`BCS_ADDR_TOUT, 32'hFFFFFF40, `BCS_RESP_OK);
        rd(`BCS_ADDR_TOUT, `BCS_RESP_OK);
        chk(v, 32'h840);
        s_axi_wstrb <= 4'hF;
        wr(`BCS_ADDR_TOUT, 32'h40, `BCS_RESP_OK);
        wr(`BCS_ADDR_TWID, 32'h8, `BCS_RESP_OK);
        rd(`BCS_ADDR_TOUT, `BCS_RESP_OK);
        chk(v, 32'h40);
        $display("test regs done");
    endtask
    task automatic t_pend;
        wait_st(4'h1);
        rises(256, 4, 4);
        temp_hot <= 1'b1;
        temp_cutoff <= 1'b1;
        repeat (8) @(posedge aclk);
        rises(256, 0, -1);
        $display("test pending done");
    endtask
    task automatic t_li;
        temp_hot <= 1'b0;
        temp_cutoff <= 1'b0;
        temp_cold <= 1'b1;
        batt_below_lbat <= 1'b0;
        batt_at_mcv <= 1'b1;
        repeat (40) @(posedge aclk);
        rd(`BCS_ADDR_STAT, `BCS_RESP_OK);
        chk(v[3:0], 4'h0);
        temp_cold <= 1'b0;
        wait_st(4'h6);
        chk(v[`BCS_STAT_LI], 1'b1);
        // end must come from low current, long before the timeout
        cur_below_min <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`BCS_ADDR_STAT, `BCS_RESP_OK);
        chk(v[3:0], 4'h7);
        rises(256, 0, -1);
        // charge timer has run out and rests at the timeout
        rd(`BCS_ADDR_TMR, `BCS_RESP_OK);
        chk(v, 32'h40);
        batt_at_mcv <= 1'b0;
        cur_below_min <= 1'b0;
        batt_below_rch <= 1'b1;
        wait_st(4'h3);
        batt_below_rch <= 1'b0;
        $display("test lithium done");
    endtask
    task automatic t_ni;
        battery_present <= 1'b0;
        wait_st(4'h8);
        wr(`BCS_ADDR_CTRL, 32'h1, `BCS_RESP_OK);
        battery_present <= 1'b1;
        wait_st(4'h3);
        smp(12'h100);
        smp(12'h0FD);
        rd(`BCS_ADDR_STAT, `BCS_RESP_OK);
        chk(v[3:0], 4'h3);
        chk(v[`BCS_STAT_KNOWN], 1'b1);
        chk(v[`BCS_STAT_LI], 1'b0);
        smp(12'h0FC);
        wait_st(4'h4);
        wait_st(4'h5);
        batt_at_mcv <= 1'b1;
        repeat (8) @(posedge aclk);
        rises(256, 0, -1);
        batt_at_mcv <= 1'b0;
        repeat (8) @(posedge aclk);
        rises(256, 4, -1);
        wr(`BCS_ADDR_CTRL, 32'h0, `BCS_RESP_OK);
        battery_present <= 1'b0;
        wait_st(4'h8);
        battery_present <= 1'b1;
        wait_st(4'h3);
        wait_st(4'h5);
        // sleep and wake start a new cycle
        wr(`BCS_ADDR_CTRL, 32'h2, `BCS_RESP_OK);
        wait_st(4'h8);
        wr(`BCS_ADDR_CTRL, 32'h0, `BCS_RESP_OK);
        wait_st(4'h3);
        $display("test nickel done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, battery_sense_valid} = '0;
        {batt_at_mcv, batt_below_rch, temp_hot, temp_cold} = '0;
        {temp_cutoff, cur_below_min} = '0;
        {batt_below_lbat, battery_present} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        battery_sense_in = 12'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_pend();
        t_li();
        t_ni();
        report_and_stop();
    end
endmodule // bcs_top_tb
`default_nettype wire
